// ==== logic/sac_regs.svh ====
// register offsets, field positions and timing counts for the converter control block
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_OFF_CTRL 8'h00
`define SAC_OFF_STATUS 8'h04
`define SAC_OFF_RESULT 8'h08
`define SAC_OFF_COUNT 8'h0c
`define SAC_CTRL_ENABLE 0
`define SAC_CTRL_FORCE_PWR 1
`define SAC_CTRL_RESET 2'h1
`define SAC_ST_ACQ 8
`define SAC_ST_HOLD 9
`define SAC_ST_BUSY 10
`define SAC_ST_INTMODE 11
`define SAC_ST_NEW 12
`define SAC_RES_NEW 16
`define SAC_CB_START 7
`define SAC_CB_CH_HI 6
`define SAC_CB_CH_LO 4
`define SAC_CB_SGL 2
`define SAC_CB_PD_HI 1
`define SAC_CB_PD_LO 0
`define SAC_BITS_MUX 4'h4
`define SAC_BITS_SGL 4'h6
`define SAC_BITS_CTRL 4'h8
`define SAC_RES_BITS 16
`define SAC_TRIAL_MSB 16'h8000
`define SAC_TRIAL_LSB 16'h0001
`define SAC_PD_AUTO 2'h0
`define SAC_PD_RSVD 2'h1
`define SAC_PD_INTCLK 2'h2
`define SAC_PD_ON 2'h3
`define SAC_INT_CONV_NS 8000
`define SAC_CLK_MHZ 100
`define SAC_INT_STEPS 17
`endif

// ==== logic/sac_pkg.sv ====
// types shared by the converter control block
package sac_pkg;
    typedef enum logic [6:0] {
        SAC_IDLE = 7'h01,
        SAC_CTRL = 7'h02,
        SAC_WAIT = 7'h04,
        SAC_BUSY = 7'h08,
        SAC_CONV = 7'h10,
        SAC_ICONV = 7'h20,
        SAC_READ = 7'h40
    } sac_state_e;

    typedef struct packed {
        sac_state_e state;
        logic prev_sclk;
        logic [7:0] shreg;
        logic [3:0] bit_cnt;
        logic [7:0] ctrl_byte;
        logic sgl;
        logic [2:0] chan;
        logic [1:0] pd;
        logic int_mode;
        logic acquire;
        logic hold;
        logic busy;
        logic dout;
        logic [15:0] trial;
        logic [15:0] result;
        logic [15:0] last_result;
        logic [15:0] dac;
        logic [7:0] pos_sel;
        logic [7:0] neg_sel;
        logic com_neg;
        logic [9:0] tick;
        logic new_flag;
        logic [15:0] conv_count;
        logic [1:0] ctrl;
        logic [31:0] prdata;
        logic pslverr;
    } sac_core_s;
endpackage

// ==== logic/sac_sync.sv ====
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module sac_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sac_sync_s;

    sac_sync_s st;
    sac_sync_s next_st;

    if (WIDTH < 1) begin : g_chk
        $error("sac_sync needs WIDTH of at least 1");
    end

    // first stage feeds only the second
    always_comb begin
        next_st = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.s2;
endmodule

// ==== logic/sac_ctrl.sv ====
// serial link, multiplexer and SAR sequencing for the eight-channel converter
// Functional notes
// R1 - single-ended code picks channel against common
// R2 - differential codes pair channels, top bit swaps
// R3 - mux configured from serially received bits
// R4 - conversion fits three byte transfers, 24 clocks
// R5 - first eight clocks capture control byte
// R6 - acquire once channel bits are known
// R7 - hold and convert after full control byte
// R8 - sixteen further clocks perform the conversion
// R9 - result is sixteen bits, reference over 65536
// R10 - four-wire select, clock, data in, data out
// R11 - start bit first, ignore input before it
// R12 - busy one period, then bits on falls
// R13 - power bits pick power and clock mode
// R14 - result MSB first, one bit per clock
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_ctrl import sac_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic select_n_in,
    input wire logic shift_clock_in,
    input wire logic cmd_data_in,
    output logic result_data_out,
    output logic result_oe_out,
    output logic busy_out,
    output logic busy_oe_out,
    input wire logic comparator_in,
    output logic [15:0] dac_code_out,
    output logic [7:0] pos_sel_out,
    output logic [7:0] neg_sel_out,
    output logic com_neg_out,
    output logic acquire_out,
    output logic hold_out,
    output logic power_up_out,
    output logic int_clk_mode_out
);
    // conversion step for internal clock mode, longest time rounded down
    localparam int unsigned STEP_CYC = (`SAC_INT_CONV_NS * `SAC_CLK_MHZ / 1000) / `SAC_INT_STEPS;
    localparam logic [9:0] STEP_LAST = 10'(STEP_CYC - 1);

    if (ADDR_W < 8 || STEP_CYC < 1 || STEP_CYC > 1024) begin : g_chk
        $error("sac_ctrl parameters out of range");
    end

    sac_core_s st;
    sac_core_s next_st;
    logic [3:0] sync_q;
    logic sclk_s;
    logic cs_n_s;
    logic din_s;
    logic cmp_s;
    logic cs_act;
    logic rise;
    logic fall;
    logic [7:0] addr8;
    logic [15:0] decided;
    logic [7:0] nsh;

    // R10 pin synchronisers
    sac_sync #(.WIDTH(4)) u_sync (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .async_in({comparator_in, cmd_data_in, select_n_in, shift_clock_in}),
        .sync_out(sync_q)
    );

    assign sclk_s = sync_q[0];
    assign cs_n_s = sync_q[1];
    assign din_s = sync_q[2];
    assign cmp_s = sync_q[3];
    assign cs_act = ~cs_n_s & st.ctrl[`SAC_CTRL_ENABLE];
    assign rise = sclk_s & ~st.prev_sclk;
    assign fall = ~sclk_s & st.prev_sclk;
    assign addr8 = paddr_in[7:0];
    // R14 keep trial bit if input exceeds trial level
    assign decided = st.result | (cmp_s ? st.trial : 16'h0000);
    assign nsh = {st.shreg[6:0], din_s};

    always_comb begin
        next_st = st;
        next_st.prev_sclk = sclk_s;

        // bus setup phase loads read data; access phase commits writes
        if (psel_in && !penable_in) begin
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h0000_0000;
            unique case (addr8)
                `SAC_OFF_CTRL: next_st.prdata = {30'h0, st.ctrl};
                `SAC_OFF_STATUS: begin
                    next_st.prdata = {19'h0, st.new_flag, st.int_mode, st.busy, st.hold, st.acquire, st.ctrl_byte};
                end
                `SAC_OFF_RESULT: next_st.prdata = {15'h0, st.new_flag, st.last_result};
                `SAC_OFF_COUNT: next_st.prdata = {16'h0, st.conv_count};
                default: next_st.pslverr = 1'b1;
            endcase
        end
        if (psel_in && penable_in) begin
            if (pwrite_in && addr8 == `SAC_OFF_CTRL) begin
                next_st.ctrl = pwdata_in[1:0];
            end
            if (!pwrite_in && addr8 == `SAC_OFF_RESULT) begin
                next_st.new_flag = 1'b0;
            end
        end

        if (!cs_act) begin
            // select high: link idles and outputs release
            next_st.state = SAC_IDLE;
            next_st.bit_cnt = 4'h0;
            next_st.acquire = 1'b0;
            next_st.hold = 1'b0;
            next_st.busy = 1'b0;
            next_st.dout = 1'b0;
            next_st.trial = 16'h0000;
        end else begin
            unique case (st.state)
                SAC_IDLE: begin
                    if (fall) begin
                        next_st.dout = 1'b0;
                    end
                    // R11 wait for start bit
                    if (rise && din_s) begin
                        next_st.state = SAC_CTRL;
                        next_st.bit_cnt = 4'h1;
                        next_st.shreg = 8'h01;
                    end
                end
                SAC_CTRL: begin
                    if (fall) begin
                        next_st.dout = 1'b0;
                    end
                    // R5 shift control bits
                    if (rise) begin
                        next_st.shreg = nsh;
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                        // R6 channel known, acquire
                        if (st.bit_cnt + 4'h1 == `SAC_BITS_MUX) begin
                            next_st.chan = nsh[2:0];
                            next_st.acquire = 1'b1;
                        end
                        // R3 mode bit from link
                        if (st.bit_cnt + 4'h1 == `SAC_BITS_SGL) begin
                            next_st.sgl = nsh[0];
                        end
                        // R7 byte complete, hold
                        if (st.bit_cnt + 4'h1 == `SAC_BITS_CTRL) begin
                            next_st.ctrl_byte = nsh;
                            next_st.pd = nsh[`SAC_CB_PD_HI:`SAC_CB_PD_LO];
                            next_st.acquire = 1'b0;
                            next_st.hold = 1'b1;
                            next_st.bit_cnt = 4'h0;
                            next_st.result = 16'h0000;
                            next_st.trial = `SAC_TRIAL_MSB;
                            next_st.tick = 10'h000;
                            // R13 clock mode takes effect one conversion late
                            next_st.int_mode = (st.pd == `SAC_PD_INTCLK);
                            if (st.pd == `SAC_PD_INTCLK) begin
                                next_st.state = SAC_ICONV;
                                next_st.busy = 1'b0;
                            end else begin
                                next_st.state = SAC_WAIT;
                            end
                        end
                    end
                end
                SAC_WAIT: begin
                    // R12 busy for one link period
                    if (fall) begin
                        next_st.busy = 1'b1;
                        next_st.state = SAC_BUSY;
                    end
                end
                SAC_BUSY: begin
                    // R12 MSB appears as busy drops
                    if (fall) begin
                        next_st.busy = 1'b0;
                        next_st.result = decided;
                        next_st.dout = cmp_s;
                        next_st.trial = st.trial >> 1;
                        next_st.state = SAC_CONV;
                    end
                end
                SAC_CONV: begin
                    // R8 one decision per further clock
                    if (fall) begin
                        next_st.result = decided;
                        next_st.dout = cmp_s;
                        next_st.trial = st.trial >> 1;
                        // R4 LSB overlaps next control byte
                        if (st.trial == `SAC_TRIAL_LSB) begin
                            next_st.state = SAC_IDLE;
                            next_st.hold = 1'b0;
                            next_st.last_result = decided;
                            next_st.new_flag = 1'b1;
                            next_st.conv_count = st.conv_count + 16'h0001;
                        end
                    end
                end
                SAC_ICONV: begin
                    // R13 self-timed steps, link clock unused
                    next_st.tick = st.tick + 10'h001;
                    if (st.tick == STEP_LAST) begin
                        next_st.tick = 10'h000;
                        next_st.result = decided;
                        next_st.trial = st.trial >> 1;
                        if (st.trial == `SAC_TRIAL_LSB) begin
                            next_st.state = SAC_READ;
                            next_st.busy = 1'b1;
                            next_st.hold = 1'b0;
                            next_st.trial = `SAC_TRIAL_MSB;
                            next_st.last_result = decided;
                            next_st.new_flag = 1'b1;
                            next_st.conv_count = st.conv_count + 16'h0001;
                        end
                    end
                end
                SAC_READ: begin
                    // R14 stored result out MSB first
                    if (fall) begin
                        next_st.dout = |(st.result & st.trial);
                        next_st.trial = st.trial >> 1;
                        if (st.trial == `SAC_TRIAL_LSB) begin
                            next_st.state = SAC_IDLE;
                            next_st.busy = 1'b0;
                        end
                    end
                end
                default: next_st.state = SAC_IDLE;
            endcase
        end

        // R9 sixteen-bit trial level for the DAC
        next_st.dac = next_st.result | next_st.trial;
        // R1 R2 positive leg from chan bits mid, lo, hi
        next_st.pos_sel = 8'h01 << {next_st.chan[1:0], next_st.chan[2]};
        next_st.neg_sel = next_st.sgl ? 8'h00 : 8'h01 << {next_st.chan[1:0], ~next_st.chan[2]};
        next_st.com_neg = next_st.sgl;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st <= '0;
            st.state <= SAC_IDLE;
            st.ctrl <= `SAC_CTRL_RESET;
            st.sgl <= 1'b1;
            st.pos_sel <= 8'h01;
            st.com_neg <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // zero wait states; read data registered in the setup phase
    assign pready_out = 1'b1;
    assign prdata_out = st.prdata;
    assign pslverr_out = st.pslverr;
    assign result_data_out = st.dout;
    assign result_oe_out = cs_act;
    assign busy_out = st.busy;
    assign busy_oe_out = cs_act;
    assign dac_code_out = st.dac;
    assign pos_sel_out = st.pos_sel;
    assign neg_sel_out = st.neg_sel;
    assign com_neg_out = st.com_neg;
    assign acquire_out = st.acquire;
    assign hold_out = st.hold;
    // R13 powered during conversions or when held on
    assign power_up_out = (st.pd == `SAC_PD_ON) | st.ctrl[`SAC_CTRL_FORCE_PWR] | (st.state != SAC_IDLE);
    assign int_clk_mode_out = (st.pd == `SAC_PD_INTCLK);

    // helper: link falls counted from busy onward
    logic [4:0] fall_cnt;
    always_ff @(posedge clock_in) begin
        if (srst_in || st.state == SAC_WAIT) begin
            fall_cnt <= 5'h00;
        end else if (fall && (st.state == SAC_BUSY || st.state == SAC_CONV)) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end

    sequence s_byte_done;
        st.state == SAC_CTRL && rise && cs_act && st.bit_cnt == 4'h7;
    endsequence

    sequence s_msb_out;
        st.state == SAC_BUSY && fall && cs_act;
    endsequence

    property p_single_map;
        @(posedge clock_in) disable iff (srst_in)
        st.sgl && $stable(st.chan) && $stable(st.sgl) |->
            com_neg_out && neg_sel_out == 8'h00 && pos_sel_out == (8'h01 << {st.chan[1:0], st.chan[2]});
    endproperty
    a_single_map: assert property (p_single_map) else $error("single-ended mux wrong"); // R1

    property p_diff_map;
        @(posedge clock_in) disable iff (srst_in)
        !st.sgl && $stable(st.chan) && $stable(st.sgl) |->
            !com_neg_out && (pos_sel_out << !st.chan[2]) == (neg_sel_out << st.chan[2]);
    endproperty
    a_diff_map: assert property (p_diff_map) else $error("differential pair wrong"); // R2

    property p_acq_start;
        @(posedge clock_in) disable iff (srst_in)
        st.state == SAC_CTRL && rise && cs_act && st.bit_cnt == 4'h3 |=> $rose(acquire_out) && st.chan == st.shreg[2:0];
    endproperty
    a_acq_start: assert property (p_acq_start) else $error("acquisition not started"); // R6

    property p_hold_after_byte;
        @(posedge clock_in) disable iff (srst_in)
        s_byte_done |=> hold_out && !acquire_out && st.trial == `SAC_TRIAL_MSB;
    endproperty
    a_hold_after_byte: assert property (p_hold_after_byte) else $error("hold not entered"); // R7

    property p_sixteen_falls;
        @(posedge clock_in) disable iff (srst_in)
        st.state == SAC_CONV && fall && cs_act && st.trial == `SAC_TRIAL_LSB |-> fall_cnt == 5'h0f ##1 !hold_out;
    endproperty
    a_sixteen_falls: assert property (p_sixteen_falls) else $error("conversion length wrong"); // R8

    property p_ignore_low;
        @(posedge clock_in) disable iff (srst_in)
        st.state == SAC_IDLE && rise && !din_s |=> st.state == SAC_IDLE;
    endproperty
    a_ignore_low: assert property (p_ignore_low) else $error("left idle without start"); // R11

    property p_busy_msb;
        @(posedge clock_in) disable iff (srst_in)
        s_msb_out |=> $fell(busy_out) && result_data_out == st.result[15];
    endproperty
    a_busy_msb: assert property (p_busy_msb) else $error("MSB not with busy end"); // R12

    property p_msb_first;
        @(posedge clock_in) disable iff (srst_in)
        st.state == SAC_CONV && fall && cs_act |=> st.trial == ($past(st.trial) >> 1) && $onehot0(st.trial);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("bit order wrong"); // R14

    property p_release;
        @(posedge clock_in) disable iff (srst_in)
        cs_n_s |-> !result_oe_out && !busy_oe_out ##1 !busy_out;
    endproperty
    a_release: assert property (p_release) else $error("outputs driven while deselected"); // R10
endmodule

// ==== dv/sac_host_model.sv ====
// host side of the serial link: shifts a control byte in and the result out
`timescale 1ns/1ps
module sac_host_model (
    output logic select_n_out,
    output logic shift_clock_out,
    output logic cmd_data_out,
    input wire logic result_line_in,
    input wire logic busy_in,
    input wire logic acquire_in,
    input wire logic hold_in
);
    initial begin
        select_n_out = 1'b1;
        shift_clock_out = 1'b0;
        cmd_data_out = 1'b0;
    end
    // clock stands low between frames; data only changes while it is low
    task automatic convert(input logic [7:0] cb, input int lead, input logic intclk, output logic [15:0] res,
        output logic [3:0] flags);
        res = 16'h0000;
        flags = 4'h0;
        // edges kept off the system clock edge
        #3;
        select_n_out = 1'b0;
        #160;
        // leading zeros, then the byte msb first
        for (int k = 1 - lead; k <= 24; k++) begin
            // internal mode: clock stays low until busy marks the result ready
            if (intclk && k == 9) wait (busy_in === 1'b1) #3;
            cmd_data_out = (k >= 1 && k <= 8) ? cb[8 - k] : 1'b0;
            #80 shift_clock_out = 1'b1;
            #80 shift_clock_out = 1'b0;
            #60;
            if (k == 3) flags[3] = acquire_in === 1'b0;
            if (k == 4) flags[0] = acquire_in === 1'b1 && hold_in === 1'b0;
            if (k == 8) flags[1] = hold_in === 1'b1 && acquire_in === 1'b0 && busy_in === !intclk;
            if (k == 9) flags[2] = busy_in === intclk;
            if (k >= 9 && k <= 24) res = {res[14:0], result_line_in};
            #20;
        end
        select_n_out = 1'b1;
        #200;
    endtask
endmodule

// ==== dv/test_sac_ctrl.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_sac_ctrl;
    logic clock_in, srst_in, psel_in, penable_in, pwrite_in, comparator_in, tick;
    logic [7:0] paddr_in, pos_sel_out, neg_sel_out, cb;
    logic [31:0] pwdata_in, prdata_out, d;
    logic pready_out, pslverr_out, select_n_in, shift_clock_in, cmd_data_in, result_data_out, result_oe_out;
    logic busy_out, busy_oe_out, com_neg_out, acquire_out, hold_out, power_up_out, int_clk_mode_out, e;
    logic [15:0] dac_code_out, res;
    logic [1:0] pd;
    logic [3:0] fl;
    logic [16:0] m;
    int errors, n_compared, lead, ev;
    int chan_v[8];

    sac_ctrl dut_u (.clock_in(clock_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .select_n_in(select_n_in),
        .shift_clock_in(shift_clock_in), .cmd_data_in(cmd_data_in), .result_data_out(result_data_out),
        .result_oe_out(result_oe_out), .busy_out(busy_out), .busy_oe_out(busy_oe_out),
        .comparator_in(comparator_in), .dac_code_out(dac_code_out), .pos_sel_out(pos_sel_out),
        .neg_sel_out(neg_sel_out), .com_neg_out(com_neg_out), .acquire_out(acquire_out), .hold_out(hold_out),
        .power_up_out(power_up_out), .int_clk_mode_out(int_clk_mode_out));
    // released pins toggle so a stale value never passes
    sac_host_model host_u (.select_n_out(select_n_in), .shift_clock_out(shift_clock_in),
        .cmd_data_out(cmd_data_in), .result_line_in(result_oe_out ? result_data_out : tick),
        .busy_in(busy_oe_out ? busy_out : tick), .acquire_in(acquire_out), .hold_in(hold_out));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) tick <= ~tick;

    function automatic int lvl(logic [7:0] s);
        int v = 0;
        for (int i = 0; i < 8; i++) if (s[i] === 1'b1) v += chan_v[i];
        return v;
    endfunction
    // analog side: comparator high while input reaches the dac level
    always @(posedge clock_in) comparator_in <= lvl(pos_sel_out) - lvl(neg_sel_out) >= int'(dac_code_out);

    function automatic logic [16:0] mux_exp(logic [7:0] c);
        int ch;
        if (c[2]) begin
            ch = {c[5], c[4], c[6]};
            return {1'b1, 8'h00, 8'h01 << ch};
        end
        ch = {c[5], c[4], 1'b0};
        return {1'b0, 8'h01 << (ch + !c[6]), 8'h01 << (ch + c[6])};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (n >= 50) chk(0, 1);
        d = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(d, exp);
        chk(e, 0);
    endtask

    initial begin
        #300000;
        errors++;
        $display("wrong value at %0t: timeout", $time);
        end_of_test();
    end

    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, comparator_in, tick} = '0;
        errors = 0;
        n_compared = 0;
        srst_in = 1'b1;
        void'($urandom(92359));
        repeat (5) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h0);
        apb(1'b1, 8'h10, 32'hffffffff);
        chk(e, 1);
        apb(1'b0, 8'h10, 32'h0);
        chk(d, 0);
        chk(e, 1);
        apb(1'b1, 8'h00, 32'h3);
        repeat (2) @(posedge clock_in);
        chk(power_up_out, 1);
        apb(1'b1, 8'h00, 32'h1);
        // pd 10 in byte 16 makes conversion 17 self-timed
        for (int n = 0; n < 18; n++) begin
            pd = 2'($urandom_range(2));
            if (pd == 2'h2) pd = 2'h3;
            cb = {1'b1, n[2:0], 1'b0, n[3], pd};
            if (n == 16) cb = {1'b1, 3'($urandom_range(7)), 2'b01, 2'h2};
            pd = cb[1:0];
            for (int i = 0; i < 8; i++) chan_v[i] = $urandom_range(65535);
            lead = $urandom_range(3);
            m = mux_exp(cb);
            ev = lvl(m[7:0]) - lvl(m[15:8]);
            if (ev < 0) ev = 0;
            fork
                host_u.convert(cb, lead, n == 17, res, fl);
                begin
                    @(posedge hold_out);
                    #20;
                    chk({com_neg_out, neg_sel_out, pos_sel_out}, m);
                end
            join
            chk(res, ev);
            chk(fl, 4'hf);
            rd(8'h08, {15'h0, 1'b1, 16'(ev)});
            rd(8'h08, {16'h0, 16'(ev)});
            apb(1'b0, 8'h04, 32'h0);
            chk(d[12:0], {1'b0, n == 17, 3'h0, cb});
            rd(8'h0c, n + 1);
            repeat (5) @(posedge clock_in);
            chk({int_clk_mode_out, power_up_out}, {pd == 2'h2, pd == 2'h3});
        end
        end_of_test();
    end
endmodule
